// ==== pfwm_pkg.sv ====
// Package of register offsets, field positions, reset values and timing for the fault monitor
package pfwm_pkg;
  localparam int PFWM_NCH = 4;
  localparam int PFWM_CLIP_CYCLES = 20;
  localparam int PFWM_RAMP_MS = 5;
  localparam int PFWM_CLK_HZ = 100_000_000;
  localparam int PFWM_RAMP_CYCLES = PFWM_RAMP_MS * (PFWM_CLK_HZ / 1000);
  localparam logic [7:0] PFWM_REG_MISC1 = 8'h01;
  localparam logic [7:0] PFWM_REG_STATE_CTRL = 8'h04;
  localparam logic [7:0] PFWM_REG_STATE_RPT = 8'h0F;
  localparam logic [7:0] PFWM_REG_CH_FAULT = 8'h10;
  localparam logic [7:0] PFWM_REG_GLOB_FAULT1 = 8'h11;
  localparam logic [7:0] PFWM_REG_GLOB_FAULT2 = 8'h12;
  localparam logic [7:0] PFWM_REG_WARNINGS = 8'h13;
  localparam logic [7:0] PFWM_REG_PIN_CTRL = 8'h14;
  localparam logic [7:0] PFWM_REG_MISC4 = 8'h21;
  localparam int PFWM_HEAT_LVL_LSB = 5;
  localparam int PFWM_CLEAR_BIT = 7;
  localparam logic [7:0] PFWM_MISC1_RST = 8'h00;
  localparam logic [7:0] PFWM_STATE_CTRL_RST = 8'h55;
  localparam logic [7:0] PFWM_PIN_CTRL_RST = 8'h00;
  // Pin-control mask bit positions
  localparam int PFWM_M_CLIP = 0;
  localparam int PFWM_M_HEAT = 1;
  localparam int PFWM_M_DC = 2;
  localparam int PFWM_M_CUR = 3;
  localparam int PFWM_M_OVERTEMP_SHUTDOWN = 4;
  localparam int PFWM_M_VOLT = 5;
  localparam int PFWM_M_CLK = 6;
  // Global fault 1 bits, then global fault 2 and warning bits
  localparam int PFWM_G_OUTPUT_STAGE_SUPPLY_UV = 0;
  localparam int PFWM_G_VBAT_UV = 1;
  localparam int PFWM_G_OUTPUT_STAGE_SUPPLY_OV = 2;
  localparam int PFWM_G_VBAT_OV = 3;
  localparam int PFWM_G_CLK = 4;
  localparam int PFWM_G_OVERTEMP_SHUTDOWN = 0;
  localparam int PFWM_W_RESET = 5;
  localparam int PFWM_W_HEAT = 4;
  localparam logic [6:0] PFWM_BUS_ADDR_BASE = 7'h6A;
  typedef enum logic [1:0] {
    PFWM_ST_STANDBY = 2'h0,
    PFWM_ST_PLAY = 2'h1,
    PFWM_ST_HIZ = 2'h2,
    PFWM_ST_MUTE = 2'h3
  } pfwm_chstate_t;
  typedef enum {PFWM_RUN, PFWM_RAMP, PFWM_OFF} pfwm_stby_t;
endpackage : pfwm_pkg

// ==== pfwm_clip_det.sv ====
// Per-channel clipping detector counting consecutive full-duty PWM cycles
module pfwm_clip_det
  import pfwm_pkg::*;
#(
  parameter int CYCLES = PFWM_CLIP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic pwm_tick,
  input wire logic full_duty,
  output logic clipping
);
  initial begin
    if (CYCLES < 1 || CYCLES > 255) $error("pfwm_clip_det: CYCLES out of range");
  end
  logic [7:0] run_len;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_len <= 8'h00;
      clipping <= 1'b0;
    end else if (clk_en && pwm_tick) begin
      if (!full_duty) begin
        run_len <= 8'h00;
        clipping <= 1'b0;
      end else if (run_len < 8'(CYCLES)) begin
        run_len <= run_len + 8'h01;
        clipping <= (run_len + 8'h01) >= 8'(CYCLES);
      end
    end
  end
endmodule // pfwm_clip_det

// ==== pfwm_monitor.sv ====
// Protection, fault and warning monitor for a four-channel amplifier
// Operation
// - DC offset over threshold: channel Hi-Z, fault flag set, error pin low.
// - Mask bit stops DC-offset faults from driving the error pin.
// - Clipping flagged after 20 consecutive full-duty PWM cycles on any channel.
// - Clipping bit is sticky; cleared by writing bit 7 of register 0x21.
// - Clipping reporting to caution pin maskable; detection unchanged.
// - Four global heat caution levels chosen by bits 6:5 of register 0x01.
// - Temperature over selected level asserts caution pin unless masked.
// - Global overtemp shutdown forces all Hi-Z, error low; auto recovery.
// - Channel heat caution sets its warning bit and caution pin unless masked.
// - Channel heat shutdown holds Hi-Z until below channel caution threshold.
// - Supply undervoltage drives error pin low and updates status.
// - Reset restores defaults, bus stays enabled, sets reset warning and caution pin.
// - Output stage overvoltage drives error pin low and updates status.
// - Error pin low while any fault other than channel heat shutdown exists; released when none remain.
// - Per-category error masks gate only the pin; all unmasked by default.
// - Caution pin latched low until bit 7 of register 0x21 is written.
// - Separate clipping and heat masks on caution pin; unmasked by default.
// - Active-low mute input mutes all playing channels while low.
// - Standby low: ramp down within 5 ms, then shut down, bus off.
// - Bus address from two select pins; write bytes 0xD4 to 0xDA.
// - Overcurrent trip: channel Hi-Z, fault reported, error pin low.
//
// The placing of the registers and the strobed register port are this design's own decisions.
module pfwm_monitor
  import pfwm_pkg::*;
#(
  parameter int NCH = PFWM_NCH,
  parameter int RAMP_CYCLES = PFWM_RAMP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic pwm_tick,
  input wire logic [NCH-1:0] full_duty,
  input wire logic [NCH-1:0] dc_offset_event,
  input wire logic [NCH-1:0] current_trip_level,
  input wire logic [3:0] junction_temp_level,
  input wire logic overtemp_shutdown,
  input wire logic [NCH-1:0] channel_heat_caution,
  input wire logic [NCH-1:0] channel_heat_shutdown,
  input wire logic output_stage_supply_supply_low_event,
  input wire logic vbat_supply_low_event,
  input wire logic output_stage_supply_supply_high_event,
  input wire logic vbat_supply_high_event,
  input wire logic clock_error,
  input wire logic mute_in_n,
  input wire logic standby_in_n,
  input wire logic bus_addr_sel_lo,
  input wire logic bus_addr_sel_hi,
  output logic [6:0] bus_address,
  output logic bus_enable,
  output logic osc_enable,
  output logic ramp_down,
  output logic [2*NCH-1:0] channel_state,
  output logic error_flag_out_n_o,
  output logic error_flag_out_n_oe,
  output logic caution_flag_out_n_o,
  output logic caution_flag_out_n_oe
);
  initial begin
    if (NCH != 4) $error("pfwm_monitor: NCH must be 4");
    if (RAMP_CYCLES < 1) $error("pfwm_monitor: RAMP_CYCLES must be positive");
  end

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
    return reg_wr && (a == off);
  endfunction

  logic [7:0] misc1;
  logic [7:0] state_ctrl;
  logic [7:0] pin_ctrl;
  logic [NCH-1:0] dc_flag;
  logic [NCH-1:0] cur_flag;
  logic [NCH-1:0] ch_heat_off;
  logic [NCH-1:0] clipping;
  logic clip_sticky;
  logic reset_warn;
  logic caution_latch;
  logic [NCH-1:0] ch_force_hiz;
  logic heat_over;
  logic clear_wr;
  logic [31:0] ramp_cnt;
  pfwm_stby_t stby_state;

  assign clear_wr = wr_hit(reg_addr, PFWM_REG_MISC4) && reg_wdata[PFWM_CLEAR_BIT];

  // Writable control registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      misc1 <= PFWM_MISC1_RST;
      state_ctrl <= PFWM_STATE_CTRL_RST;
      pin_ctrl <= PFWM_PIN_CTRL_RST;
    end else if (clk_en) begin
      if (wr_hit(reg_addr, PFWM_REG_MISC1)) misc1 <= reg_wdata;
      if (wr_hit(reg_addr, PFWM_REG_STATE_CTRL)) state_ctrl <= reg_wdata;
      if (wr_hit(reg_addr, PFWM_REG_PIN_CTRL)) pin_ctrl <= reg_wdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_clip
      pfwm_clip_det #(.CYCLES(PFWM_CLIP_CYCLES)) u_clip (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pwm_tick(pwm_tick),
        .full_duty(full_duty[g]),
        .clipping(clipping[g])
      );
    end
  endgenerate

  // Channel fault flags: cleared by the clear bit, a new event wins over clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dc_flag <= '0;
      cur_flag <= '0;
    end else if (clk_en) begin
      dc_flag <= (clear_wr ? '0 : dc_flag) | dc_offset_event;
      cur_flag <= (clear_wr ? '0 : cur_flag) | current_trip_level;
    end
  end

  // Channel heat shutdown holds until the channel drops below its caution level
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ch_heat_off <= '0;
    end else if (clk_en) begin
      ch_heat_off <= channel_heat_shutdown | (ch_heat_off & channel_heat_caution);
    end
  end

  // Global heat caution: level 0..3 from misc1 compared to thermometer input
  assign heat_over = junction_temp_level[misc1[PFWM_HEAT_LVL_LSB +: 2]];

  // Sticky clipping and reset warning
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clip_sticky <= 1'b0;
      reset_warn <= 1'b1;
    end else if (clk_en) begin
      clip_sticky <= (clear_wr ? 1'b0 : clip_sticky) | (|clipping);
      if (clear_wr) reset_warn <= 1'b0;
    end
  end

  logic caution_src;
  assign caution_src = ((|clipping) && !pin_ctrl[PFWM_M_CLIP])
    || ((heat_over || (|channel_heat_caution)) && !pin_ctrl[PFWM_M_HEAT]);

  // Caution pin latch; a new cause in the clearing cycle keeps it set
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      caution_latch <= 1'b1;
    end else if (clk_en) begin
      caution_latch <= (clear_wr ? 1'b0 : caution_latch) | caution_src;
    end
  end

  logic supply_low;
  logic supply_high;
  logic error_now;
  assign supply_low = output_stage_supply_supply_low_event || vbat_supply_low_event;
  assign supply_high = output_stage_supply_supply_high_event || vbat_supply_high_event;
  assign error_now = ((|dc_flag) && !pin_ctrl[PFWM_M_DC])
    || ((|cur_flag) && !pin_ctrl[PFWM_M_CUR])
    || (overtemp_shutdown && !pin_ctrl[PFWM_M_OVERTEMP_SHUTDOWN])
    || (supply_low && !pin_ctrl[PFWM_M_VOLT])
    || (supply_high && !pin_ctrl[PFWM_M_VOLT])
    || (clock_error && !pin_ctrl[PFWM_M_CLK]);

  // Open-drain pins: drive low only
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      error_flag_out_n_oe <= 1'b0;
      caution_flag_out_n_oe <= 1'b0;
    end else if (clk_en) begin
      error_flag_out_n_oe <= error_now;
      caution_flag_out_n_oe <= caution_latch;
    end
  end
  assign error_flag_out_n_o = 1'b0;
  assign caution_flag_out_n_o = 1'b0;

  // Standby sequencing: ramp down first, then stop oscillator and bus
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stby_state <= PFWM_RUN;
      ramp_cnt <= 32'h0000_0000;
    end else if (clk_en) begin
      unique case (stby_state)
        PFWM_RUN: begin
          if (!standby_in_n) begin
            stby_state <= PFWM_RAMP;
            ramp_cnt <= 32'h0000_0000;
          end
        end
        PFWM_RAMP: begin
          if (standby_in_n) begin
            stby_state <= PFWM_RUN;
          end else if (ramp_cnt >= 32'(RAMP_CYCLES - 1)) begin
            stby_state <= PFWM_OFF;
          end else begin
            ramp_cnt <= ramp_cnt + 32'h0000_0001;
          end
        end
        PFWM_OFF: begin
          if (standby_in_n) stby_state <= PFWM_RUN;
        end
      endcase
    end
  end

  logic in_standby;
  assign in_standby = (stby_state == PFWM_OFF);
  assign bus_enable = !in_standby;
  assign osc_enable = !in_standby;
  assign ramp_down = (stby_state == PFWM_RAMP);
  // Added, not ORed: the base has bit 1 set, so an OR would fold two select codes together
  assign bus_address = PFWM_BUS_ADDR_BASE + {5'h00, bus_addr_sel_hi, bus_addr_sel_lo};

  // Per-channel effective state
  logic supply_bad;
  assign supply_bad = supply_low || supply_high;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ch_force_hiz[i] = dc_flag[i] || cur_flag[i] || ch_heat_off[i]
        || overtemp_shutdown || supply_bad;
    end
  end

  logic [2*NCH-1:0] next_channel_state;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (in_standby) begin
        next_channel_state[2*i +: 2] = PFWM_ST_STANDBY;
      end else if (ch_force_hiz[i] || ramp_down) begin
        next_channel_state[2*i +: 2] = PFWM_ST_HIZ;
      end else if (!mute_in_n && state_ctrl[2*i +: 2] == PFWM_ST_PLAY) begin
        next_channel_state[2*i +: 2] = PFWM_ST_MUTE;
      end else begin
        next_channel_state[2*i +: 2] = state_ctrl[2*i +: 2];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_state <= {NCH{PFWM_ST_HIZ}};
    end else if (clk_en) begin
      channel_state <= next_channel_state;
    end
  end

  // Register read port, data in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd) begin
        unique case (reg_addr)
          PFWM_REG_MISC1: reg_rdata <= misc1;
          PFWM_REG_STATE_CTRL: reg_rdata <= state_ctrl;
          PFWM_REG_STATE_RPT: reg_rdata <= channel_state;
          PFWM_REG_CH_FAULT: reg_rdata <= {cur_flag, dc_flag};
          PFWM_REG_GLOB_FAULT1: reg_rdata <= {3'h0, clock_error, vbat_supply_high_event,
            output_stage_supply_supply_high_event, vbat_supply_low_event, output_stage_supply_supply_low_event};
          PFWM_REG_GLOB_FAULT2: reg_rdata <= {ch_heat_off, 3'h0, overtemp_shutdown};
          PFWM_REG_WARNINGS: reg_rdata <= {1'b0, clip_sticky, reset_warn, heat_over,
            channel_heat_caution};
          PFWM_REG_PIN_CTRL: reg_rdata <= pin_ctrl;
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule // pfwm_monitor

// ==== pfwm_monitor_props.sv ====
// Port-level checker for the protection and warning monitor
module pfwm_monitor_props
  import pfwm_pkg::*;
#(
  parameter int NCH = PFWM_NCH,
  parameter int RAMP_CYCLES = PFWM_RAMP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [NCH-1:0] dc_offset_event,
  input wire logic [NCH-1:0] current_trip_level,
  input wire logic overtemp_shutdown,
  input wire logic [NCH-1:0] channel_heat_shutdown,
  input wire logic output_stage_supply_supply_low_event,
  input wire logic vbat_supply_low_event,
  input wire logic output_stage_supply_supply_high_event,
  input wire logic vbat_supply_high_event,
  input wire logic standby_in_n,
  input wire logic bus_addr_sel_lo,
  input wire logic bus_addr_sel_hi,
  input wire logic [6:0] bus_address,
  input wire logic bus_enable,
  input wire logic ramp_down,
  input wire logic [2*NCH-1:0] channel_state,
  input wire logic error_flag_out_n_oe,
  input wire logic caution_flag_out_n_oe
);
  logic [7:0] mask;
  wire logic clr = reg_wr && reg_addr == 8'h21 && reg_wdata[7];
  // Shadow of the pin masks, as the checker sees only the ports
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) mask <= 8'h00;
    else if (reg_wr && reg_addr == 8'h14) mask <= reg_wdata;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_addr_map: assert property (bus_address == 7'h6A + {5'h00, bus_addr_sel_hi, bus_addr_sel_lo})
    else $error("bus address wrong");
  a_low_volt: assert property ((output_stage_supply_supply_low_event || vbat_supply_low_event) && !mask[5]
    |=> error_flag_out_n_oe) else $error("undervoltage not on error pin");
  a_high_volt: assert property ((output_stage_supply_supply_high_event || vbat_supply_high_event) && !mask[5]
    |=> error_flag_out_n_oe) else $error("overvoltage not on error pin");
  a_overtemp_shutdown_all: assert property (overtemp_shutdown && !mask[4]
    |=> error_flag_out_n_oe ##[0:2] channel_state == {NCH{2'h2}}) else $error("shutdown missed");
  a_dc_hiz: assert property (dc_offset_event[0] |-> ##[1:3] channel_state[1:0] == 2'h2)
    else $error("offset channel not off");
  a_cur_err: assert property (current_trip_level[1] && !mask[3] |=> error_flag_out_n_oe)
    else $error("current trip not on error pin");
  a_heat_hiz: assert property (channel_heat_shutdown[2] |-> ##[1:3] channel_state[5:4] == 2'h2)
    else $error("hot channel not off");
  a_stby_ramp: assert property ($fell(standby_in_n) |-> ##[1:2] ramp_down)
    else $error("no ramp on standby");
  a_stby_off: assert property (!standby_in_n && !ramp_down && $past(ramp_down) |-> !bus_enable)
    else $error("bus alive after ramp");
  a_caution_hold: assert property (caution_flag_out_n_oe && !clr && !$past(clr) && !$past(clr, 2)
    |=> caution_flag_out_n_oe) else $error("caution released without clear");
endmodule // pfwm_monitor_props
bind pfwm_monitor pfwm_monitor_props #(.NCH(NCH), .RAMP_CYCLES(RAMP_CYCLES)) u_props (.*);

// ==== pfwm_host.sv ====
// Register master standing in for the system processor
module pfwm_host (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle bus shows inverted values so stale data never passes for fresh
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask
  task automatic clr();
    wr(8'h21, 8'h80);
  endtask
endmodule // pfwm_host

// ==== tb.sv ====
// Self-checking bench for the protection and warning monitor
module tb;
  import pfwm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RAMP = 20;
  logic sys_clk = 1'b0, sys_rst = 1'b1, pwm_tick = 1'b0, mute_in_n = 1'b1, standby_in_n = 1'b1;
  logic [3:0] full_duty = 4'h0, dc = 4'h0, cur = 4'h0, temp = 4'h0, hc = 4'h0, hs = 4'h0;
  logic [5:0] gev = 6'h00;
  logic [1:0] sel = 2'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, channel_state;
  logic reg_wr, reg_rd, err_oe, cau_oe, bus_enable, osc_enable, ramp_down;
  logic [6:0] bus_address;
  int bad_count = 0, num_checks = 0, cyc = 0, seed = 32'h85bb, ch;
  always #5 sys_clk = ~sys_clk;
  pfwm_host host (.*);
  pfwm_monitor #(.RAMP_CYCLES(RAMP)) dut (.*, .clk_en(1'b1), .dc_offset_event(dc),
    .current_trip_level(cur), .junction_temp_level(temp), .overtemp_shutdown(gev[5]),
    .channel_heat_caution(hc), .channel_heat_shutdown(hs), .output_stage_supply_supply_low_event(gev[0]),
    .vbat_supply_low_event(gev[1]), .output_stage_supply_supply_high_event(gev[2]),
    .vbat_supply_high_event(gev[3]), .clock_error(gev[4]), .bus_addr_sel_lo(sel[0]),
    .bus_addr_sel_hi(sel[1]), .error_flag_out_n_o(), .error_flag_out_n_oe(err_oe),
    .caution_flag_out_n_o(), .caution_flag_out_n_oe(cau_oe));
  function automatic logic [7:0] st(int c, logic [1:0] v);
    logic [7:0] s;
    s = PFWM_STATE_CTRL_RST;
    s[2*c +: 2] = v;
    return s;
  endfunction
  function automatic int mbit(int e);
    return e < 4 ? PFWM_M_VOLT : (e == 4 ? PFWM_M_CLK : PFWM_M_OVERTEMP_SHUTDOWN);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic go(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Checks wait for the registered pin and flag stages to land
  task automatic settle();
    go(4);
    @(negedge sys_clk);
  endtask
  task automatic tick();
    go(1);
    pwm_tick <= 1'b1;
    go(1);
    pwm_tick <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    go(2);
    @(negedge sys_clk);
    chk(channel_state, 8'hAA);
    go(1);
    sys_rst <= 1'b0;
    settle();
    chk1(cau_oe, 1'b1);
    chk1(err_oe, 1'b0);
    host.rd(8'h13, d);
    chk(d, 8'h20);
    host.rd(8'h14, d);
    chk(d, PFWM_PIN_CTRL_RST);
    host.rd(8'h04, d);
    chk(d, PFWM_STATE_CTRL_RST);
    host.wr(8'h10, 8'hFF);
    host.rd(8'h10, d);
    chk(d, 8'h00);
    host.rd(8'h3C, d);
    chk(d, 8'h00);
    host.clr();
    settle();
    chk1(cau_oe, 1'b0);
    for (int i = 0; i < 4; i++) begin
      go(1);
      sel <= 2'(i);
      settle();
      chk(8'(bus_address), 8'(PFWM_BUS_ADDR_BASE + 7'(i)));
    end
    for (int m = 0; m < 2; m++) begin
      ch = $unsigned($random(seed)) % 4;
      host.wr(8'h14, 8'(m));
      go(1);
      full_duty[ch] <= 1'b1;
      repeat (19) tick();
      settle();
      chk1(cau_oe, 1'b0);
      tick();
      settle();
      chk1(cau_oe, m == 0);
      go(1);
      full_duty <= 4'h0;
      // The detector only drops clipping on a PWM boundary without full duty
      tick();
      settle();
      chk1(cau_oe, m == 0);
      host.rd(8'h13, d);
      chk(d, 8'h40);
      host.clr();
      host.rd(8'h13, d);
      chk(d, 8'h00);
    end
    host.wr(8'h14, 8'h00);
    for (int l = 0; l < 4; l++) begin
      host.wr(8'h01, 8'(l << 5));
      host.rd(8'h01, d);
      chk(d, 8'(l << 5));
      go(1);
      temp <= ~(4'hF << l);
      settle();
      chk1(cau_oe, 1'b0);
      go(1);
      temp <= ~(4'hE << l);
      settle();
      chk1(cau_oe, 1'b1);
      go(1);
      temp <= 4'h0;
      settle();
      host.clr();
      settle();
      chk1(cau_oe, 1'b0);
    end
    ch = $unsigned($random(seed)) % 4;
    go(1);
    hc[ch] <= 1'b1;
    settle();
    chk1(cau_oe, 1'b1);
    host.rd(8'h13, d);
    chk(d & 8'h0F, 8'(1 << ch));
    go(1);
    hs[ch] <= 1'b1;
    settle();
    chk(channel_state, st(ch, 2'h2));
    go(1);
    hs[ch] <= 1'b0;
    settle();
    chk(channel_state, st(ch, 2'h2));
    go(1);
    hc[ch] <= 1'b0;
    settle();
    chk(channel_state, PFWM_STATE_CTRL_RST);
    host.clr();
    for (int i = 0; i < 12; i++) begin
      host.wr(8'h14, 8'(i % 2) << mbit(i / 2));
      go(1);
      gev[i/2] <= 1'b1;
      settle();
      chk1(err_oe, i % 2 == 0);
      if (i >= 10) chk(channel_state, 8'hAA);
      host.rd(i < 10 ? 8'h11 : 8'h12, d);
      chk(d, i < 10 ? 8'(1 << (i / 2)) : 8'h01);
      go(1);
      gev <= 6'h00;
      settle();
      chk1(err_oe, 1'b0);
      chk(channel_state, PFWM_STATE_CTRL_RST);
    end
    go(1);
    mute_in_n <= 1'b0;
    settle();
    chk(channel_state, 8'hFF);
    go(1);
    mute_in_n <= 1'b1;
    settle();
    chk(channel_state, PFWM_STATE_CTRL_RST);
    for (int i = 0; i < 4; i++) begin
      ch = $unsigned($random(seed)) % 4;
      host.wr(8'h14, 8'(i % 2) << (i < 2 ? PFWM_M_DC : PFWM_M_CUR));
      go(1);
      if (i < 2) dc[ch] <= 1'b1;
      else cur[ch] <= 1'b1;
      settle();
      chk(channel_state[2*ch +: 2], 8'h02);
      go(1);
      dc <= 4'h0;
      cur <= 4'h0;
      settle();
      chk1(err_oe, i % 2 == 0);
      host.rd(8'h10, d);
      chk(d, 8'(1 << (ch + (i < 2 ? 0 : 4))));
      host.clr();
      settle();
      chk1(err_oe, 1'b0);
    end
    go(1);
    standby_in_n <= 1'b0;
    settle();
    chk1(ramp_down, 1'b1);
    go(RAMP);
    @(negedge sys_clk);
    chk1(bus_enable, 1'b0);
    chk1(osc_enable, 1'b0);
    go(1);
    standby_in_n <= 1'b1;
    settle();
    chk1(bus_enable, 1'b1);
    stop_test();
  end
endmodule // tb
